// ===== inc/acc_defs.svh
// Constants of the codec control-mode block: slot numbers, field positions,
// reset values and timing counts.
// Assumes the includer works on the 25 MHz system clock.
`ifndef ACC_DEFS_SVH
`define ACC_DEFS_SVH

// Slot numbers, counted from zero for slot 1
`define ACC_SLOT_STATUS   3'h0
`define ACC_SLOT_FORMAT   3'h1
`define ACC_SLOT_LINK     3'h2
`define ACC_SLOT_TEST     3'h3
`define ACC_SLOT_REVISION 3'h6

// Status register fields
`define ACC_ST_RANGE      3
`define ACC_ST_LATCH      2
`define ACC_ST_MASK       8'h0C

// Format register fields
`define ACC_FMT_RATE      5:3
`define ACC_FMT_STEREO    2
`define ACC_FMT_CODING    1:0
`define ACC_CODING_RSV    2'h3

// Link register fields
`define ACC_LNK_IMMEDIATE 7
`define ACC_LNK_SOURCE    5:4
`define ACC_LNK_FLEN      3:2
`define ACC_LNK_DIRECTION 1
`define ACC_LNK_SDO_DIS   0
`define ACC_FLEN_64       2'h0
`define ACC_FLEN_128      2'h1
`define ACC_FLEN_RSV      2'h3

// Test register fields
`define ACC_TST_LOOP_EN   1
`define ACC_TST_LOOP_PATH 0

// Reset values
`define ACC_STATUS_RST    8'h00
`define ACC_FORMAT_RST    8'h00
`define ACC_LINK_RST      8'h00
`define ACC_TEST_RST      8'h00

// Frame and timing counts
`define ACC_FRAME_LAST    6'h3F
`define ACC_SLOT_LAST     3'h7
`define ACC_RELEASE_LAST  4'hB
`define ACC_CAL_CYCLES    9'h100
`define ACC_SCLK_HALF     2'h2

`endif

// ===== inc/acc_link_if.sv
// Carries the self-made bit clock and frame sync between the generator and
// the control block; all signals live on the system clock.
`timescale 1ns/1ps
`default_nettype none

interface acc_link_if;
  logic       run;
  logic [1:0] frameLen;
  logic       sclk;
  logic       frame_sync;
  logic       sclkFall;

  modport gen  (input run, frameLen, output sclk, frame_sync, sclkFall);
  modport user (output run, frameLen, input sclk, frame_sync, sclkFall);
endinterface

`default_nettype wire

// ===== inc/acc_pkg.sv
// Types shared by the codec control-mode block.
// Assumes nothing beyond the compile order.
package acc_pkg;

  typedef enum logic [1:0] {
    DRV_OFF     = 2'h0,
    DRV_ON      = 2'h1,
    DRV_RELEASE = 2'h2
  } acc_drv_state_type;

endpackage

// ===== testbench/acc_ctrl_model.sv
// Controller side of the framed control link: bit clock, frame sync, data.
// Assumes the bench calls frame() only while it owns the link clock.
`timescale 1ns/1ps
`default_nettype none

module acc_ctrl_model (
  input  wire logic sdFromCodec,
  output logic      sclk,
  output logic      frameSync,
  output logic      sdToCodec
);
  initial begin
    sclk      = 1'b0;
    frameSync = 1'b0;
    sdToCodec = 1'b0;
  end

  // 320 ns per bit; clock idles low between frames, trailing fall preps bit 0
  task automatic frame(input logic [63:0] tx, output logic [63:0] rx);
    for (int i = 0; i < 64; i++) begin
      sdToCodec = tx[63-i];
      frameSync = (i == 0);
      #160;
      sclk = 1'b1;
      #159;
      rx[63-i] = sdFromCodec;
      #1;
      sclk = 1'b0;
    end
    frameSync = 1'b0;
    // Released line must not keep showing the last bit
    sdToCodec = ~sdToCodec;
  endtask
endmodule // acc_ctrl_model

`default_nettype wire

// ===== testbench/audio_codec_control_mode_regs_bench.sv
// Self-checking bench for the codec control-mode register block.
// Assumes the controller model owns the link clock unless the codec drives it.
`timescale 1ns/1ps
`default_nettype none

module audio_codec_control_mode_regs_bench;
  localparam logic [7:0] REV = 8'hC3; // Arbitrary value

  logic        clk, arstN, modeBit;
  logic        sdOut, sdOutEn, sclkOut, sclkOutEn, fsOut, fsOutEn, dataMode, calBusy;
  logic        rangeSel, latchFlag, stereoSel, immRel, clkDir, outDis, loopEn, loopPath;
  logic [2:0]  rateCode;
  logic [1:0]  coding, srcSel, flenSel, c, fl, expCod, expFl;
  logic [63:0] rx;
  logic        pf, ps;
  int          miscompares, samplesChecked, cycles, n;
  wire logic   mSclk, mFs, mSd, sclkPin, fsPin, sdLine;

  // Codec wins the wire only while its enables are up
  assign sclkPin = sclkOutEn ? sclkOut : mSclk;
  assign fsPin   = fsOutEn ? fsOut : mFs;
  assign sdLine  = sdOutEn ? sdOut : ~clk;

  acc_ctrl_model model (.sdFromCodec(sdLine), .sclk(mSclk), .frameSync(mFs), .sdToCodec(mSd));

  acc_codec_ctrl #(.REVISION(REV)) dut (
    .clk(clk), .arst_n(arstN), .ce(1'b1), .modeSelectPortBit(modeBit),
    .sclkIn(sclkPin), .frameSyncIn(fsPin), .sdIn(mSd),
    .sdOut(sdOut), .sdOutEn(sdOutEn), .sclkOut(sclkOut), .sclkOutEn(sclkOutEn),
    .frameSyncOut(fsOut), .frameSyncOutEn(fsOutEn), .dataMode(dataMode), .calBusy(calBusy),
    .outputRangeSel(rangeSel), .controlLatchFlag(latchFlag), .conversionRateCode(rateCode),
    .stereoSel(stereoSel), .sampleCoding(coding), .immediateRelease(immRel),
    .clockSourceSel(srcSel), .frameLengthSel(flenSel), .clockDirection(clkDir),
    .serialOutDisable(outDis), .loopbackEnable(loopEn), .loopbackPathSel(loopPath)
  );

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endOfTest;
    $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Ceiling well above the ~20 frames and four mode changes of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      endOfTest();
    end
  end

  task automatic xfer(input logic [31:0] regs);
    @(negedge clk); // Link edges kept off the sampling edge
    model.frame({regs, 32'h0000_0000}, rx);
  endtask

  task automatic checkRx(input logic [63:0] exp);
    for (int j = 0; j < 4; j++)
      check(rx[16*j +: 16], exp[16*j +: 16]);
  endtask

  // Latch, two ignored frames, then mode pin high
  task automatic enterData(input logic [7:0] lnk);
    xfer({8'h04, 8'h01, lnk, 8'h00});
    check(latchFlag, 1'b1);
    xfer(32'h0802_1802);
    xfer(32'h0802_1802);
    check({coding, loopEn, sdOutEn}, 4'h4);
    @(posedge clk);
    modeBit <= 1'b1;
    n = 0;
    repeat (300) begin
      @(negedge clk);
      if (calBusy === 1'b1)
        n++;
    end
    check(n[15:0], 16'h0100);
    check(dataMode, 1'b1);
  endtask

  // Generated bit clock rises from one frame sync rise to the next
  task automatic frameBits(input int exp);
    int k;
    k = 0;
    pf = 1'b1;
    while (k < 3000 && !(pf === 1'b0 && fsOut === 1'b1)) begin
      pf = fsOut;
      @(negedge clk);
      k++;
    end
    n = 0;
    pf = 1'b1;
    while (k < 3000 && !(pf === 1'b0 && fsOut === 1'b1)) begin
      pf = fsOut;
      ps = sclkOut;
      @(negedge clk);
      k++;
      if (ps === 1'b0 && sclkOut === 1'b1)
        n++;
    end
    check(n[15:0], exp[15:0]);
  endtask

  initial begin
    arstN   = 1'b0;
    modeBit = 1'b0;
    repeat (8) @(posedge clk);
    arstN <= 1'b1;
    repeat (4) @(negedge clk);
    check({rangeSel, latchFlag, stereoSel, immRel, clkDir, outDis, loopEn, loopPath}, 0);
    check({rateCode, coding, srcSel, flenSel}, 0);
    xfer(32'h0835_9403);
    checkRx({32'h0000_0000, 8'h00, 8'h00, REV, 8'h00});
    xfer(32'hFB35_9403);
    checkRx({32'h0835_9403, 8'h00, 8'h00, REV, 8'h00});
    check(rangeSel, 1'b1);
    check(rateCode, 3'h6);
    check(stereoSel, 1'b1);
    check(coding, 2'h1);
    check({immRel, srcSel, flenSel}, 5'h15);
    check({clkDir, outDis, sdOutEn}, 3'h1);
    check({loopEn, loopPath}, 2'h3);
    expCod = 2'h1;
    expFl  = 2'h1;
    for (int i = 0; i < 8; i++) begin
      c  = i[1:0];
      fl = c ^ 2'h2;
      if (c != 2'h3)
        expCod = c;
      if (fl != 2'h3)
        expFl = fl;
      xfer({8'h00, 2'b00, i[2:0], 1'b0, c, i[2], 1'b0, c, fl, 2'b00, 8'h00});
      check(coding, expCod);
      check(flenSel, expFl);
      check(srcSel, c);
      check(rateCode, i[2:0]);
      check(immRel, i[2]);
    end
    xfer(32'h0001_1901);
    check({outDis, sdOutEn}, 2'h2);
    enterData(8'h16);
    check({sclkOutEn, fsOutEn}, 2'h3);
    frameBits(128);
    @(posedge clk);
    modeBit <= 1'b0;
    n  = 0;
    ps = sclkOut;
    for (int k = 0; k < 150 && sclkOutEn !== 1'b0; k++) begin
      @(negedge clk);
      if (k == 8)
        check(sclkOutEn, 1'b1);
      if (ps === 1'b1 && sclkOut === 1'b0)
        n++;
      ps = sclkOut;
    end
    check((n >= 12 && n <= 13) ? 16'h0001 : 16'h0000, 16'h0001);
    check({sclkOutEn, fsOutEn, latchFlag, dataMode}, 4'h2);
    enterData(8'h92);
    frameBits(64);
    @(posedge clk);
    modeBit <= 1'b0;
    repeat (8) @(negedge clk);
    check({sclkOutEn, fsOutEn}, 2'h0);
    endOfTest();
  end
endmodule // audio_codec_control_mode_regs_bench

`default_nettype wire

// ===== verilog/acc_clkgen.sv
// Bit clock and frame sync generator used while the codec is timing master.
// Assumes the system clock; frame length 64, 128 or 256 bits.
`timescale 1ns/1ps
`default_nettype none

`include "acc_defs.svh"

module acc_clkgen (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  acc_link_if.gen   lnk
);
  logic [1:0] divCnt;
  logic [7:0] bitCnt;
  logic [7:0] lastBit;
  logic       halfDone;

  assign lastBit  = (lnk.frameLen == `ACC_FLEN_64)  ? 8'h3F :
                    (lnk.frameLen == `ACC_FLEN_128) ? 8'h7F : 8'hFF;
  assign halfDone = (divCnt == `ACC_SCLK_HALF - 2'h1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt       <= 2'h0;
      bitCnt       <= 8'h00;
      lnk.sclk     <= 1'b0;
      lnk.frame_sync    <= 1'b0;
      lnk.sclkFall <= 1'b0;
    end else if (ce) begin
      lnk.sclkFall <= lnk.run && halfDone && lnk.sclk;
      if (!lnk.run) begin
        divCnt    <= 2'h0;
        bitCnt    <= 8'h00;
        lnk.sclk  <= 1'b0;
        lnk.frame_sync <= 1'b0;
      end else if (halfDone) begin
        divCnt   <= 2'h0;
        lnk.sclk <= !lnk.sclk;
        if (lnk.sclk) begin
          // Sync marks bit 0 of each frame, set on the falling edge before it
          bitCnt    <= (bitCnt >= lastBit) ? 8'h00 : bitCnt + 8'h01;
          lnk.frame_sync <= (bitCnt >= lastBit);
        end
      end else begin
        divCnt <= divCnt + 2'h1;
      end
    end
  end
endmodule // acc_clkgen

`default_nettype wire

// ===== verilog/acc_codec_ctrl.sv
// Control-mode register block of a stereo codec on a framed serial link.
// Assumes the controller drives bit clock and frame sync in control mode.
// Summary of operation
// - Mode pin low gives control mode: bytes written in, status bytes read out.
// - Eight 8-bit slots per frame map to status, format, link, test, revision.
// - Status bit 3 selects reduced full-scale output levels when set.
// - Status bit 2 latches control; after that frame writes are ignored.
// - Format bits 5:3 select conversion rate with the active crystal.
// - Format bits 1:0 select coding; reserved code 11 is not taken.
// - Link bit 7 releases clock drivers at once, else 12 clocks later.
// - Link bits 5:4 select the master clock source.
// - Link bits 3:2 select 64, 128 or 256 bits per frame; 11 refused.
// - Link bit 1 set makes the codec drive bit clock and frame sync in data mode.
// - Link bit 0 set disables the serial data output driver.
// - Test bit 1 enables loopback, bit 0 picks digital or analog path.
// - A frame holds eight slots of eight bits, 64 bits, MSB first.
// - Mode pin high enters data mode and starts offset calibration.
`timescale 1ns/1ps
`default_nettype none

`include "acc_defs.svh"

module acc_codec_ctrl
  import acc_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h5A // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       modeSelectPortBit,
  input  wire logic       sclkIn,
  input  wire logic       frameSyncIn,
  input  wire logic       sdIn,
  output logic            sdOut,
  output logic            sdOutEn,
  output logic            sclkOut,
  output logic            sclkOutEn,
  output logic            frameSyncOut,
  output logic            frameSyncOutEn,
  output logic            dataMode,
  output logic            calBusy,
  output wire logic       outputRangeSel,
  output wire logic       controlLatchFlag,
  output wire logic [2:0] conversionRateCode,
  output wire logic       stereoSel,
  output wire logic [1:0] sampleCoding,
  output wire logic       immediateRelease,
  output wire logic [1:0] clockSourceSel,
  output wire logic [1:0] frameLengthSel,
  output wire logic       clockDirection,
  output wire logic       serialOutDisable,
  output wire logic       loopbackEnable,
  output wire logic       loopbackPathSel
);

  logic [3:0]        syncQ;
  logic              modeS;
  logic              sclkS;
  logic              frameSyncS;
  logic              sdS;
  logic              sclkPrev;
  logic [5:0]        bitIdx;
  logic [6:0]        rxShift;
  logic [7:0]        statusReg;
  logic [7:0]        formatReg;
  logic [7:0]        linkReg;
  logic [7:0]        testReg;
  logic              writesLatched;
  logic [8:0]        calCnt;
  logic [3:0]        relCnt;
  acc_drv_state_type drvState;
  acc_drv_state_type next_drvState;

  acc_link_if link ();

  acc_sync #(
    .W (4)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .d      ({modeSelectPortBit, sclkIn, frameSyncIn, sdIn}),
    .q      (syncQ)
  );

  acc_clkgen u_clkgen (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .lnk    (link)
  );

  assign modeS      = syncQ[3];
  assign sclkS      = syncQ[2];
  assign frameSyncS = syncQ[1];
  assign sdS        = syncQ[0];

  // Edge and mode decode; rising edges count as control bits only in control mode while drvState is DRV_OFF
  wire       sclkRise = sclkS && !sclkPrev;
  wire       sclkFall = !sclkS && sclkPrev;
  wire       modeRise = modeS && !dataMode;
  wire       modeFall = !modeS && dataMode;
  wire [5:0] curIdx   = frameSyncS ? 6'h00 : bitIdx;
  wire [7:0] wrByte   = {rxShift, sdS};
  wire [2:0] wrSlot   = curIdx[5:3];
  wire       ctlRise  = sclkRise && !dataMode && (drvState == DRV_OFF);
  wire       wrEn     = ctlRise && !writesLatched
                        && (curIdx[2:0] == `ACC_SLOT_LAST);
  wire       frameEnd = ctlRise && (curIdx == `ACC_FRAME_LAST);

  // Writes of reserved codes keep the previous setting
  wire       codingRsv = (wrByte[`ACC_FMT_CODING] == `ACC_CODING_RSV);
  wire       flenRsv   = (wrByte[`ACC_LNK_FLEN] == `ACC_FLEN_RSV);
  wire [7:0] next_formatReg = {wrByte[7:2],
                               codingRsv ? formatReg[`ACC_FMT_CODING]
                                         : wrByte[`ACC_FMT_CODING]};
  wire [7:0] next_linkReg   = {wrByte[7:4],
                               flenRsv ? linkReg[`ACC_LNK_FLEN]
                                       : wrByte[`ACC_LNK_FLEN],
                               wrByte[1:0]};

  // Read-back byte of the slot now on the wire; unused slots read zero
  wire [2:0] txSlot = bitIdx[5:3];
  wire [7:0] slotData =
    (txSlot == `ACC_SLOT_STATUS)   ? statusReg :
    (txSlot == `ACC_SLOT_FORMAT)   ? formatReg :
    (txSlot == `ACC_SLOT_LINK)     ? linkReg   :
    (txSlot == `ACC_SLOT_TEST)     ? testReg   :
    (txSlot == `ACC_SLOT_REVISION) ? REVISION  : 8'h00;

  // Register fields as seen by the converter side
  assign outputRangeSel     = statusReg[`ACC_ST_RANGE];
  assign controlLatchFlag   = statusReg[`ACC_ST_LATCH];
  assign conversionRateCode = formatReg[`ACC_FMT_RATE];
  assign stereoSel          = formatReg[`ACC_FMT_STEREO];
  assign sampleCoding       = formatReg[`ACC_FMT_CODING];
  assign immediateRelease   = linkReg[`ACC_LNK_IMMEDIATE];
  assign clockSourceSel     = linkReg[`ACC_LNK_SOURCE];
  assign frameLengthSel     = linkReg[`ACC_LNK_FLEN];
  assign clockDirection     = linkReg[`ACC_LNK_DIRECTION];
  assign serialOutDisable   = linkReg[`ACC_LNK_SDO_DIS];
  assign loopbackEnable     = testReg[`ACC_TST_LOOP_EN];
  assign loopbackPathSel    = testReg[`ACC_TST_LOOP_PATH];

  assign link.run      = (drvState != DRV_OFF);
  assign link.frameLen = frameLengthSel;

  // Serial shift and slot counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev <= 1'b0;
      bitIdx   <= 6'h00;
      rxShift  <= 7'h00;
    end else if (ce) begin
      sclkPrev <= sclkS;
      if (ctlRise) begin
        rxShift <= wrByte[6:0];
        bitIdx  <= curIdx + 6'h01;
      end
    end
  end

  // Register writes, one byte per slot at its last bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statusReg <= `ACC_STATUS_RST;
      formatReg <= `ACC_FORMAT_RST;
      linkReg   <= `ACC_LINK_RST;
      testReg   <= `ACC_TEST_RST;
    end else if (ce && wrEn) begin
      if (wrSlot == `ACC_SLOT_STATUS)
        statusReg <= wrByte & `ACC_ST_MASK;
      if (wrSlot == `ACC_SLOT_FORMAT)
        formatReg <= next_formatReg;
      if (wrSlot == `ACC_SLOT_LINK)
        linkReg <= next_linkReg;
      // Upper test bits are kept as written; the controller leaves them zero
      if (wrSlot == `ACC_SLOT_TEST)
        testReg <= wrByte;
    end
  end

  // Latch: a frame ending with the flag high locks out writes and the driver
  // until control mode is entered anew. Set wins over the clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      writesLatched <= 1'b0;
    end else if (ce) begin
      if (frameEnd && controlLatchFlag)
        writesLatched <= 1'b1;
      else if (modeFall)
        writesLatched <= 1'b0;
    end
  end

  // Data output changes on the falling bit clock, MSB first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdOut   <= 1'b0;
      sdOutEn <= 1'b0;
    end else if (ce) begin
      if (sclkFall)
        sdOut <= slotData[~bitIdx[2:0]];
      sdOutEn <= !dataMode && !writesLatched && !serialOutDisable;
    end
  end

  // Mode tracking and offset calibration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataMode <= 1'b0;
      calCnt   <= 9'h000;
      calBusy  <= 1'b0;
    end else if (ce) begin
      dataMode <= modeS;
      if (modeRise)
        calCnt <= `ACC_CAL_CYCLES;
      else if (calCnt != 9'h000)
        calCnt <= calCnt - 9'h001;
      calBusy <= modeRise || (calCnt > 9'h001);
    end
  end

  // Clock driver state: on in data mode as master, released after mode falls
  always_comb begin
    next_drvState = drvState;
    unique case (drvState)
      DRV_OFF: begin
        if (modeRise && clockDirection)
          next_drvState = DRV_ON;
      end
      DRV_ON: begin
        if (modeFall)
          next_drvState = immediateRelease ? DRV_OFF : DRV_RELEASE;
      end
      DRV_RELEASE: begin
        if (modeRise)
          next_drvState = DRV_ON;
        else if (link.sclkFall && relCnt == `ACC_RELEASE_LAST)
          next_drvState = DRV_OFF;
      end
      default: next_drvState = DRV_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drvState <= DRV_OFF;
      relCnt   <= 4'h0;
    end else if (ce) begin
      drvState <= next_drvState;
      if (drvState != DRV_RELEASE || next_drvState != DRV_RELEASE)
        relCnt <= 4'h0;
      else if (link.sclkFall)
        relCnt <= relCnt + 4'h1;
    end
  end

  // Pin drivers registered once more so every output leaves a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkOut        <= 1'b0;
      sclkOutEn      <= 1'b0;
      frameSyncOut   <= 1'b0;
      frameSyncOutEn <= 1'b0;
    end else if (ce) begin
      sclkOut        <= link.sclk;
      frameSyncOut   <= link.frame_sync;
      sclkOutEn      <= (drvState != DRV_OFF);
      frameSyncOutEn <= (drvState != DRV_OFF);
    end
  end

  AST_STATUS_WR: assert property (@(posedge clk) disable iff (!arst_n)
    ce && wrEn && wrSlot == `ACC_SLOT_STATUS
    |=> outputRangeSel == $past(wrByte[3]) && statusReg[7:4] == 4'h0)
    else $error("Status write did not set the range bit");

  AST_RATE_WR: assert property (@(posedge clk) disable iff (!arst_n)
    ce && wrEn && wrSlot == `ACC_SLOT_FORMAT
    |=> conversionRateCode == $past(wrByte[5:3]))
    else $error("Rate code not taken from format write");

  AST_CODING_RSV: assert property (@(posedge clk) disable iff (!arst_n)
    ce && wrEn && wrSlot == `ACC_SLOT_FORMAT && wrByte[1:0] == 2'h3
    |=> $stable(sampleCoding))
    else $error("Reserved coding was accepted");

  AST_FLEN_RSV: assert property (@(posedge clk) disable iff (!arst_n)
    ce && wrEn && wrSlot == `ACC_SLOT_LINK && wrByte[3:2] == 2'h3
    |=> $stable(frameLengthSel))
    else $error("Reserved frame length was accepted");

  AST_LATCH: assert property (@(posedge clk) disable iff (!arst_n)
    ce && frameEnd && controlLatchFlag
    |=> writesLatched ##1 !sdOutEn)
    else $error("Latched frame did not release the data driver");

  AST_SDO_DIS: assert property (@(posedge clk) disable iff (!arst_n)
    ce && serialOutDisable |=> !sdOutEn)
    else $error("Data driver on while disabled");

  AST_REL_NOW: assert property (@(posedge clk) disable iff (!arst_n)
    ce && drvState == DRV_ON && modeFall && immediateRelease
    |=> drvState == DRV_OFF ##1 (!ce || !sclkOutEn))
    else $error("Immediate release did not stop clock drive");

  AST_REL_LATE: assert property (@(posedge clk) disable iff (!arst_n)
    relCnt <= 4'hC && (drvState == DRV_RELEASE || relCnt == 4'h0))
    else $error("Release count out of range");

  AST_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
    ce && ctlRise && curIdx == 6'h3F |=> bitIdx == 6'h00)
    else $error("Frame did not wrap after 64 bits");

  AST_CAL: assert property (@(posedge clk) disable iff (!arst_n)
    ce && modeRise |=> calBusy && dataMode)
    else $error("Calibration not started on data mode entry");

endmodule // acc_codec_ctrl

`default_nettype wire

// ===== verilog/acc_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain.
// Assumes the inputs are levels held for several clock cycles.
`timescale 1ns/1ps
`default_nettype none

module acc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else if (ce) begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule // acc_sync

`default_nettype wire
